// ---- weld_ext_io_dev.sv ----
/*
  Welder end of the external contact link: samples the controller contacts,
  filters schedule and start closures, sequences one light output and
  returns end and monitor result pulses.
  Assumes a controller on the link and welder internals on the user side
  that report warm-up and the end of each light output.
*/
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
module weld_ext_io_dev #(
  parameter int TICK_CYCLES_P = ext_io_pkg::TICK_CYCLES
) (
  input  wire logic                             clk_i,
  input  wire logic                             sys_rst_i,
  input  wire logic                             clk_en_i,
  ext_io_if.device                              lnk,
  input  wire logic [2:0]                       sched_acc_sel_i,
  input  wire logic [2:0]                       start_acc_sel_i,
  input  wire logic [1:0]                       result_len_sel_i,
  input  wire logic                             warm_i,
  input  wire logic                             emit_done_i,
  input  wire logic                             emit_ok_i,
  output logic                                  pump_diode_en_o,
  output logic                                  guide_light_o,
  output logic      [ext_io_pkg::BEAM_W-1:0]    shutter_open_o,
  output logic                                  fire_o,
  output logic      [ext_io_pkg::SCHED_W-1:0]   fire_sched_o,
  output logic      [ext_io_pkg::BEAM_W-1:0]    fire_beam_o
);
  import ext_io_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Decoders for the configuration selects
  function automatic logic [CNT_W-1:0] acc_ticks(input logic [2:0] sel);
    case (sel)
      ACC_0M1:  acc_ticks = CNT_W'(ACC_0M1_US / TICK_US);
      ACC_1MS:  acc_ticks = CNT_W'(ACC_1MS_US / TICK_US);
      ACC_2MS:  acc_ticks = CNT_W'(ACC_2MS_US / TICK_US);
      ACC_8MS:  acc_ticks = CNT_W'(ACC_8MS_US / TICK_US);
      ACC_16MS: acc_ticks = CNT_W'(ACC_16MS_US / TICK_US);
      default:  acc_ticks = CNT_W'(ACC_4MS_US / TICK_US);
    endcase
  endfunction : acc_ticks

  function automatic logic [CNT_W-1:0] res_ticks(input logic [1:0] sel);
    case (sel)
      RES_30MS: res_ticks = CNT_W'(RES_30MS_US / TICK_US);
      RES_40MS: res_ticks = CNT_W'(RES_40MS_US / TICK_US);
      default:  res_ticks = CNT_W'(RES_20MS_US / TICK_US);
    endcase
  endfunction : res_ticks

  //////////////////////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_FIRE,
    DEV_RESULT
  } dev_state_t;

  typedef struct packed {
    logic [LINK_W-1:0]  s1;
    logic [LINK_W-1:0]  s2;
    logic [PRE_W-1:0]   pre;
    logic [SCHED_W-1:0] sch_cand;
    logic [SCHED_W-1:0] sch;
    logic [CNT_W-1:0]   sch_cnt;
    logic [CNT_W-1:0]   st_cnt;
    logic [CNT_W-1:0]   res_cnt;
    logic               armed;
    dev_state_t         state;
    logic               ext_ok;
    logic               diode_en;
    logic               diode_rdy;
    logic               ready;
    logic               end_pulse;
    logic               mon_ok;
    logic               mon_trb;
    logic               guide;
    logic [BEAM_W-1:0]  shutter;
    logic               fire;
    logic [SCHED_W-1:0] fire_sch;
    logic [BEAM_W-1:0]  fire_beam;
  } dev_q_t;

  dev_q_t           q;
  dev_q_t           d;
  logic             tick;
  logic             ext;
  logic             start;
  logic [SCHED_W-1:0] sch_in;
  logic [CNT_W-1:0] sch_acc;
  logic [CNT_W-1:0] st_acc;

  // Coarse 0.1 ms tick keeps all counters narrow; filters resolve one tick
  assign tick    = (q.pre == PRE_W'(TICK_CYCLES_P - 1));
  assign ext     = q.s2[IN_CTRL];
  assign start   = ext & q.s2[IN_START];
  assign sch_in  = q.s2[IN_SCHED +: SCHED_W];
  // One tick more than the setting: the first tick may fall right after the closure,
  // so a full acceptance time always passes before a schedule or start is taken
  assign sch_acc = acc_ticks(sched_acc_sel_i) + 1'b1;
  assign st_acc  = acc_ticks(start_acc_sel_i) + 1'b1;

  //////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d      = q;
    // Contacts come from outside the clock domain
    d.s1   = {lnk.sched_sel, lnk.beam_sel, lnk.laser_start, lnk.pump_diode_on,
              lnk.ctrl_switch, lnk.guide_light};
    d.s2   = q.s1;
    d.pre  = tick ? '0 : q.pre + 1'b1;
    d.fire = 1'b0;

    // With control switching open every other contact is ignored
    d.ext_ok    = ext;
    d.diode_en  = ext & q.s2[IN_PUMP];
    d.diode_rdy = q.diode_en & warm_i;
    d.guide     = ext & q.s2[IN_GUIDE];
    d.shutter   = ext ? q.s2[IN_BEAM +: BEAM_W] : '0;

    // Schedule filter restarts on any change of the combination
    if (ext) begin
      if (sch_in != q.sch_cand) begin
        d.sch_cand = sch_in;
        d.sch_cnt  = '0;
      end else if (q.sch_cnt != sch_acc) begin
        if (tick) begin
          d.sch_cnt = q.sch_cnt + 1'b1;
        end
      end else begin
        d.sch = q.sch_cand;
      end
    end

    // Light possible: diodes up, a shutter open and no output in progress
    d.ready = ext & q.diode_rdy & (|q.shutter) & (q.sch != '0)
              & (q.state == DEV_IDLE);

    // Start filter; a new start needs the contact to open again first
    if (!start) begin
      d.st_cnt = '0;
      d.armed  = 1'b1;
    end else if (tick && q.st_cnt != st_acc) begin
      d.st_cnt = q.st_cnt + 1'b1;
    end

    case (q.state)
      DEV_IDLE: begin
        if (start && q.armed && q.st_cnt == st_acc) begin
          d.armed = 1'b0;
          if (q.ready) begin
            d.fire      = 1'b1;
            d.fire_sch  = q.sch;
            d.fire_beam = q.shutter;
            d.state     = DEV_FIRE;
          end
        end
      end
      DEV_FIRE: begin
        if (emit_done_i) begin
          d.end_pulse = 1'b1;
          d.mon_ok    = emit_ok_i;
          d.mon_trb   = ~emit_ok_i;
          d.res_cnt   = '0;
          d.state     = DEV_RESULT;
        end
      end
      DEV_RESULT: begin
        if (tick) begin
          d.res_cnt = q.res_cnt + 1'b1;
        end
        if (q.res_cnt == res_ticks(result_len_sel_i)) begin
          d.end_pulse = 1'b0;
          d.mon_ok    = 1'b0;
          d.mon_trb   = 1'b0;
          d.state     = DEV_IDLE;
        end
      end
      default: begin
        d.state = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  assign lnk.ext_accept  = q.ext_ok;
  assign lnk.diode_ready = q.diode_rdy;
  assign lnk.ready       = q.ready;
  assign lnk.end_out     = q.end_pulse;
  assign lnk.mon_ok      = q.mon_ok;
  assign lnk.mon_trouble = q.mon_trb;
  assign pump_diode_en_o = q.diode_en;
  assign guide_light_o   = q.guide;
  assign shutter_open_o  = q.shutter;
  assign fire_o          = q.fire;
  assign fire_sched_o    = q.fire_sch;
  assign fire_beam_o     = q.fire_beam;

endmodule : weld_ext_io_dev

// ---- ext_io_pkg.sv ----
/*
  Shared constants for the dry-contact external control link of a pulsed laser welder:
  timing, link field positions, configuration codes and the controller register map.
  Assumes a single 20 MHz clock on both ends; all timing runs on a 0.1 ms tick.
*/
package ext_io_pkg;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Clock and tick
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int PRE_W       = 16;
  localparam int CNT_W       = 12;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Link widths and field positions of the sampled input vector
  localparam int SCHED_W  = 8;
  localparam int BEAM_W   = 2;
  localparam int LINK_W   = SCHED_W + BEAM_W + 4;
  localparam int IN_GUIDE = 0;
  localparam int IN_CTRL  = 1;
  localparam int IN_PUMP  = 2;
  localparam int IN_START = 3;
  localparam int IN_BEAM  = 4;
  localparam int IN_SCHED = IN_BEAM + BEAM_W;

  // Welder output vector as sampled by the controller
  localparam int RET_W      = 6;
  localparam int RET_ACCEPT = 0;
  localparam int RET_DIODE  = 1;
  localparam int RET_READY  = 2;
  localparam int RET_END    = 3;
  localparam int RET_OK     = 4;
  localparam int RET_TRBL   = 5;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Acceptance time select codes; code 0 is the reset default
  localparam logic [2:0] ACC_4MS  = 3'h0;
  localparam logic [2:0] ACC_0M1  = 3'h1;
  localparam logic [2:0] ACC_1MS  = 3'h2;
  localparam logic [2:0] ACC_2MS  = 3'h3;
  localparam logic [2:0] ACC_8MS  = 3'h4;
  localparam logic [2:0] ACC_16MS = 3'h5;
  localparam int ACC_0M1_US  = 100;
  localparam int ACC_1MS_US  = 1000;
  localparam int ACC_2MS_US  = 2000;
  localparam int ACC_4MS_US  = 4000;
  localparam int ACC_8MS_US  = 8000;
  localparam int ACC_16MS_US = 16000;

  // Result pulse length select codes; code 0 is the reset default
  localparam logic [1:0] RES_20MS = 2'h0;
  localparam logic [1:0] RES_30MS = 2'h1;
  localparam logic [1:0] RES_40MS = 2'h2;
  localparam int RES_20MS_US = 20000;
  localparam int RES_30MS_US = 30000;
  localparam int RES_40MS_US = 40000;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Controller waits
  localparam int BEAM_WAIT_US  = 151000;
  localparam int SCHED_WAIT_US = 17000;
  localparam int START_HOLD_US = 20000;
  localparam int STOP_GAP_US   = 10000;
  localparam int BEAM_WAIT_TICKS  = BEAM_WAIT_US / TICK_US;
  localparam int SCHED_WAIT_TICKS = SCHED_WAIT_US / TICK_US;
  localparam int START_HOLD_TICKS = START_HOLD_US / TICK_US;
  localparam int STOP_GAP_TICKS   = STOP_GAP_US / TICK_US;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Controller register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SCHED  = 8'h04;
  localparam logic [7:0] REG_START  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_EXT   = 0;
  localparam int CTRL_PUMP  = 1;
  localparam int CTRL_GUIDE = 2;
  localparam int CTRL_BEAM  = 3;
  localparam int START_GO   = 0;
  localparam int START_PEND = 0;
  localparam int START_ON   = 1;
  localparam int ST_ACCEPT  = 0;
  localparam int ST_DIODE   = 1;
  localparam int ST_READY   = 2;
  localparam int ST_DONE    = 3;
  localparam int ST_OK      = 4;
  localparam int ST_TRBL    = 5;

endpackage : ext_io_pkg

// ---- ext_io_if.sv ----
/*
  Contact-level link between the welder and the external controller.
  Every signal is a closed (1) or open (0) dry contact; no clock travels on it.
*/
`timescale 1ns/1ps
interface ext_io_if;
  logic [ext_io_pkg::SCHED_W-1:0] sched_sel;
  logic [ext_io_pkg::BEAM_W-1:0]  beam_sel;
  logic                           laser_start;
  logic                           pump_diode_on;
  logic                           ctrl_switch;
  logic                           guide_light;
  logic                           ext_accept;
  logic                           diode_ready;
  logic                           ready;
  logic                           end_out;
  logic                           mon_ok;
  logic                           mon_trouble;

  modport device (
    input  sched_sel, beam_sel, laser_start, pump_diode_on, ctrl_switch, guide_light,
    output ext_accept, diode_ready, ready, end_out, mon_ok, mon_trouble
  );
  modport plc (
    output sched_sel, beam_sel, laser_start, pump_diode_on, ctrl_switch, guide_light,
    input  ext_accept, diode_ready, ready, end_out, mon_ok, mon_trouble
  );
endinterface : ext_io_if

// ---- plc_ext_io_ctl.sv ----
/*
  Controller end of the welder external link: drives the contacts from a small
  register file and paces schedule changes, beam waits, start pulses and stop.
  Assumes the welder end on the same link; software uses the plain strobe port.
*/
`timescale 1ns/1ps
module plc_ext_io_ctl #(
  parameter int TICK_CYCLES_P = ext_io_pkg::TICK_CYCLES
) (
  input  wire logic                            clk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            clk_en_i,
  ext_io_if.plc                                lnk,
  input  wire logic [ext_io_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [ext_io_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                            we_i,
  input  wire logic                            re_i,
  output logic      [ext_io_pkg::DATA_W-1:0]   rdata_o
);
  import ext_io_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [RET_W-1:0]   s1;
    logic [RET_W-1:0]   s2;
    logic [RET_W-1:0]   prev;
    logic [PRE_W-1:0]   pre;
    logic               ext_req;
    logic               pump_req;
    logic               ext_pin;
    logic               pump_pin;
    logic               guide;
    logic [BEAM_W-1:0]  beam;
    logic [SCHED_W-1:0] sch_new;
    logic [SCHED_W-1:0] sch_pin;
    logic               sch_gap;
    logic [CNT_W-1:0]   beam_t;
    logic [CNT_W-1:0]   sched_t;
    logic [CNT_W-1:0]   hold_t;
    logic [CNT_W-1:0]   gap_t;
    logic               start_pend;
    logic               start_on;
    logic [2:0]         sticky;
    logic [DATA_W-1:0]  rdata;
  } ctl_q_t;

  ctl_q_t q;
  ctl_q_t d;
  logic   tick;

  assign tick = (q.pre == PRE_W'(TICK_CYCLES_P - 1));

  //////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d      = q;
    d.s1   = {lnk.mon_trouble, lnk.mon_ok, lnk.end_out, lnk.ready, lnk.diode_ready,
              lnk.ext_accept};
    d.s2   = q.s1;
    d.prev = q.s2;
    d.pre  = tick ? '0 : q.pre + 1'b1;
    if (tick && q.beam_t != CNT_W'(BEAM_WAIT_TICKS)) begin
      d.beam_t = q.beam_t + 1'b1;
    end
    if (tick && q.sched_t != CNT_W'(SCHED_WAIT_TICKS)) begin
      d.sched_t = q.sched_t + 1'b1;
    end
    // Old lines open until the next tick, then the new combination closes
    if (q.sch_gap && tick) begin
      d.sch_pin = q.sch_new;
      d.sch_gap = 1'b0;
      d.sched_t = '0;
    end
    // Diodes go off first, control switching only after a gap
    if (q.ext_req) begin
      d.ext_pin  = 1'b1;
      d.pump_pin = q.pump_req;
      d.gap_t    = '0;
    end else begin
      d.pump_pin = 1'b0;
      if (q.pump_pin) begin
        d.gap_t = '0;
      end else if (tick && q.gap_t != CNT_W'(STOP_GAP_TICKS)) begin
        d.gap_t = q.gap_t + 1'b1;
      end
      if (q.gap_t == CNT_W'(STOP_GAP_TICKS)) begin
        d.ext_pin = 1'b0;
      end
    end
    // Start waits out beam and schedule settling, then holds the contact
    if (q.start_on) begin
      if (tick) begin
        d.hold_t = q.hold_t + 1'b1;
      end
      // One tick beyond the count: the first tick may come right after the closure
      if (q.hold_t == CNT_W'(START_HOLD_TICKS + 1)) begin
        d.start_on = 1'b0;
      end
    end else if (q.start_pend && !q.sch_gap && q.beam_t == CNT_W'(BEAM_WAIT_TICKS)
                 && q.sched_t == CNT_W'(SCHED_WAIT_TICKS)) begin
      d.start_on   = 1'b1;
      d.start_pend = 1'b0;
      d.hold_t     = '0;
    end
    if (we_i) begin
      case (addr_i)
        REG_CTRL: begin
          d.ext_req  = wdata_i[CTRL_EXT];
          d.pump_req = wdata_i[CTRL_PUMP];
          d.guide    = wdata_i[CTRL_GUIDE];
          d.beam     = wdata_i[CTRL_BEAM +: BEAM_W];
          if (wdata_i[CTRL_BEAM +: BEAM_W] != q.beam) begin
            d.beam_t = '0;
          end
        end
        REG_SCHED: begin
          d.sch_new = wdata_i[SCHED_W-1:0];
          d.sch_pin = '0;
          d.sch_gap = 1'b1;
          d.sched_t = '0;
        end
        REG_START: begin
          if (wdata_i[START_GO]) begin
            d.start_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Write-one clears; a result edge in the same cycle wins
    if (we_i && addr_i == REG_STATUS) begin
      d.sticky = q.sticky & ~wdata_i[ST_TRBL:ST_DONE];
    end
    d.sticky = d.sticky | {q.s2[RET_TRBL] & ~q.prev[RET_TRBL],
                           q.s2[RET_OK] & ~q.prev[RET_OK],
                           q.s2[RET_END] & ~q.prev[RET_END]};
    d.rdata = '0;
    if (re_i) begin
      case (addr_i)
        REG_CTRL:   d.rdata = DATA_W'({q.beam, q.guide, q.pump_req, q.ext_req});
        REG_SCHED:  d.rdata = DATA_W'(q.sch_new);
        REG_START:  d.rdata = DATA_W'({q.start_on, q.start_pend});
        REG_STATUS: d.rdata = DATA_W'({q.sticky, q.s2[RET_READY], q.s2[RET_DIODE],
                                       q.s2[RET_ACCEPT]});
        default:    d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  assign lnk.ctrl_switch   = q.ext_pin;
  assign lnk.pump_diode_on = q.pump_pin;
  assign lnk.guide_light   = q.guide;
  assign lnk.beam_sel      = q.beam;
  assign lnk.sched_sel     = q.sch_pin;
  assign lnk.laser_start   = q.start_on;
  assign rdata_o           = q.rdata;

endmodule : plc_ext_io_ctl

// ---- ext_io_properties.sv ----
/*
  Concurrent checks on the contact link between the welder end and the controller end.
  Assumes one clock and an active-high asynchronous reset shared by both ends.
*/
`timescale 1ns/1ps
module ext_io_properties #(
  parameter int TICK_CYCLES_P = ext_io_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic laser_start,
  input wire logic pump_diode_on,
  input wire logic ctrl_switch,
  input wire logic ext_accept,
  input wire logic diode_ready,
  input wire logic ready,
  input wire logic end_out,
  input wire logic mon_ok,
  input wire logic mon_trouble
);
  import ext_io_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Run lengths of end output and start contact; wide enough for the full tick
  logic [23:0] end_len_q;
  logic [23:0] start_len_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      end_len_q   <= 24'h0;
      start_len_q <= 24'h0;
    end else begin
      end_len_q   <= end_out ? end_len_q + 24'h1 : 24'h0;
      start_len_q <= laser_start ? start_len_q + 24'h1 : 24'h0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  //////////////////////////////////////////////////////////////////////////////////////////
  a_mon_exclusive: assert property (!(mon_ok && mon_trouble))
    else $error("both monitor outputs closed");
  a_end_with_monitor: assert property ($rose(end_out) |-> (mon_ok || mon_trouble))
    else $error("end output without monitor result");
  a_monitor_in_end: assert property ((mon_ok || mon_trouble) |-> end_out)
    else $error("monitor output outside end output");
  a_result_length: assert property ($fell(end_out) |->
    (end_len_q >= 24'(200 * TICK_CYCLES_P - TICK_CYCLES_P)) &&
    (end_len_q <= 24'(400 * TICK_CYCLES_P + TICK_CYCLES_P)))
    else $error("end output length out of range");
  a_accept_follows: assert property ($rose(ctrl_switch) |-> ##[2:4] ext_accept)
    else $error("external acceptable not returned");
  a_stop_releases: assert property (!ctrl_switch [*4] |-> !ext_accept && !ready)
    else $error("outputs held with control switching open");
  a_diode_off: assert property (!pump_diode_on [*6] |-> !diode_ready)
    else $error("diode status without request");
  a_ready_needs_ext: assert property (ready |->
    $past(ext_accept) && $past(diode_ready))
    else $error("ready without external control and diodes");
  // A start that fires drops ready; the contact must have stood one tick at least
  a_start_filtered: assert property ($fell(ready) && laser_start &&
    $past(ext_accept) && $past(diode_ready) |-> start_len_q >= 24'(TICK_CYCLES_P))
    else $error("start taken before acceptance time");
  // The start contact must stand a full hold time on every request
  a_start_hold: assert property ($fell(laser_start) |->
    start_len_q >= 24'(START_HOLD_TICKS * TICK_CYCLES_P))
    else $error("start contact opened too early");

  c_shot_ok: cover property ($rose(end_out) && mon_ok);
  c_shot_trouble: cover property ($rose(end_out) && mon_trouble);
  c_stop: cover property ($fell(ctrl_switch));
endmodule : ext_io_properties

// ---- external_io_weld_seq_tb.sv ----
/*
  Self-checking bench: controller end and welder end joined by the contact link.
  Assumes a short tick parameter so that millisecond times stay cheap to run.
*/
`timescale 1ns/1ps
module external_io_weld_seq_tb;
  import ext_io_pkg::*;
  localparam int T     = 4;
  localparam int LIMIT = 80000;

  logic              clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              clk_en = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic              we = 1'b0;
  logic              re = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [2:0]        sched_acc_sel = 3'h0;
  logic [2:0]        start_acc_sel = 3'h0;
  logic [1:0]        result_len_sel = 2'h0;
  logic              warm = 1'b0;
  logic              emit_done = 1'b0;
  logic              emit_ok = 1'b0;
  logic              pump_en;
  logic              guide_o;
  logic [BEAM_W-1:0] shutter;
  logic              fire;
  logic [SCHED_W-1:0] fire_sched;
  logic [BEAM_W-1:0] fire_beam;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                n_fire = 0;
  logic [31:0]       d;

  always #25 clk_i = ~clk_i;

  ext_io_if lnk ();
  plc_ext_io_ctl #(.TICK_CYCLES_P(T)) u_plc_ext_io_ctl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en), .lnk(lnk), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata));
  weld_ext_io_dev #(.TICK_CYCLES_P(T)) u_weld_ext_io_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en), .lnk(lnk), .sched_acc_sel_i(sched_acc_sel),
    .start_acc_sel_i(start_acc_sel), .result_len_sel_i(result_len_sel), .warm_i(warm),
    .emit_done_i(emit_done),
    .emit_ok_i(emit_ok), .pump_diode_en_o(pump_en), .guide_light_o(guide_o),
    .shutter_open_o(shutter), .fire_o(fire), .fire_sched_o(fire_sched), .fire_beam_o(fire_beam));
  ext_io_properties #(.TICK_CYCLES_P(T)) u_ext_io_properties (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .laser_start(lnk.laser_start), .pump_diode_on(lnk.pump_diode_on),
    .ctrl_switch(lnk.ctrl_switch), .ext_accept(lnk.ext_accept), .diode_ready(lnk.diode_ready),
    .ready(lnk.ready), .end_out(lnk.end_out), .mon_ok(lnk.mon_ok), .mon_trouble(lnk.mon_trouble));

  //////////////////////////////////////////////////////////////////////////////////////////
  function automatic int acc_ticks(input logic [2:0] c);
    case (c)
      ACC_0M1: return ACC_0M1_US / TICK_US;
      ACC_1MS: return ACC_1MS_US / TICK_US;
      ACC_2MS: return ACC_2MS_US / TICK_US;
      ACC_8MS: return ACC_8MS_US / TICK_US;
      ACC_16MS: return ACC_16MS_US / TICK_US;
      default: return ACC_4MS_US / TICK_US;
    endcase
  endfunction : acc_ticks

  function automatic int res_ticks(input logic [1:0] c);
    case (c)
      RES_30MS: return RES_30MS_US / TICK_US;
      RES_40MS: return RES_40MS_US / TICK_US;
      default: return RES_20MS_US / TICK_US;
    endcase
  endfunction : res_ticks

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(posedge clk_i);
    we    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample at that negedge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_i);
    re   <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask : rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic shot(input logic [7:0] s, input logic [2:0] sa, input logic [2:0] ta,
                      input logic [1:0] rl, input logic ok);
    int k;
    int n;
    int a;
    logic [31:0] v;
    @(posedge clk_i);
    sched_acc_sel  <= sa;
    start_acc_sel  <= ta;
    result_len_sel <= rl;
    wr(REG_SCHED, {24'h0, s});
    repeat (SCHED_WAIT_TICKS * T) @(negedge clk_i);
    for (k = 0; k < 40000 && lnk.ready !== 1'b1; k++) @(negedge clk_i);
    check({31'h0, lnk.ready}, 32'h1);
    wr(REG_START, 32'h1);
    for (k = 0; k < LIMIT && lnk.laser_start !== 1'b1; k++) @(negedge clk_i);
    for (n = 0; n < LIMIT && fire !== 1'b1; n++) @(negedge clk_i);
    // A full acceptance time must pass before the output starts
    a = acc_ticks(ta) * T;
    check({31'h0, n >= a && n <= a + 2 * T + 6}, 32'h1);
    check({24'h0, fire_sched}, {24'h0, s});
    check({30'h0, fire_beam}, 32'h1);
    @(posedge clk_i);
    emit_done <= 1'b1;
    emit_ok   <= ok;
    @(posedge clk_i);
    emit_done <= 1'b0;
    for (k = 0; k < LIMIT && lnk.end_out !== 1'b1; k++) @(negedge clk_i);
    check({30'h0, lnk.mon_ok, lnk.mon_trouble}, {30'h0, ok, !ok});
    for (n = 0; n < LIMIT && lnk.end_out === 1'b1; n++) @(negedge clk_i);
    a = res_ticks(rl) * T;
    check({31'h0, n >= a - T && n <= a + 2 * T}, 32'h1);
    rd(REG_STATUS, v);
    check(v & 32'h3B, {26'h0, !ok, ok, 1'b1, 1'b0, 2'h3});
    wr(REG_STATUS, 32'h38);
  endtask : shot

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (fire === 1'b1) n_fire <= n_fire + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(79));
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, d);
    check(d, 32'h0);
    @(posedge clk_i);
    warm <= 1'b1;
    wr(REG_CTRL, 32'h0F);
    rd(REG_CTRL, d);
    check(d, 32'h0F);
    repeat (10 * T) @(negedge clk_i);
    check({31'h0, lnk.ext_accept}, 32'h1);
    check({28'h0, pump_en, guide_o, shutter}, 32'hD);
    // Clock enable low: a write must leave no trace
    @(posedge clk_i);
    clk_en <= 1'b0;
    wr(REG_CTRL, 32'h0);
    @(posedge clk_i);
    clk_en <= 1'b1;
    rd(REG_CTRL, d);
    check(d, 32'h0F);
    // Every start code once, every result code twice; first and last schedules are edge values
    for (int i = 0; i < 6; i++) begin
      shot(i == 0 ? 8'h01 : (i == 5 ? 8'h80 : 8'($urandom_range(255, 1))), 3'(5 - i), 3'(i),
           2'(i % 3), 1'($urandom_range(1, 0)));
    end
    check(n_fire, 32'd6);
    // Cold module: ready must stay open and a start must not fire
    @(posedge clk_i);
    warm <= 1'b0;
    repeat (20 * T) @(negedge clk_i);
    check({31'h0, lnk.ready}, 32'h0);
    wr(REG_START, 32'h1);
    repeat (400 * T) @(negedge clk_i);
    check(n_fire, 32'd6);
    @(posedge clk_i);
    warm <= 1'b1;
    wr(REG_CTRL, 32'h0);
    repeat ((STOP_GAP_TICKS + 20) * T) @(negedge clk_i);
    rd(REG_STATUS, d);
    check(d & 32'h7, 32'h0);
    check({28'h0, pump_en, guide_o, shutter}, 32'h0);
    finish_test();
  end
endmodule : external_io_weld_seq_tb
